// ### lpc_host.sv
// Host-side command sequencer that drives a mobile DDR memory within its timing limits.
//
// Overview of operation
// [RQ1] Activates to one bank are spaced by row-active time plus precharge period.
// [RQ2] A read or write waits the activate-to-access delay after its bank's activate.
// [RQ3] Activates to different banks are spaced by the bank-to-bank delay.
// [RQ4] A read waits the write-to-read delay after the last write data.
// [RQ5] No command follows self-refresh exit before the exit delay.
// [RQ6] No command follows power-down exit before the exit delay.
// [RQ7] Clock enable holds each level for at least its minimum width.
// [RQ8] After a status read, the next command waits read latency plus one.
// [RQ9] The write strobe is driven valid no later than the preamble edge.
// [RQ10] The memory returns first read data read latency cycles after the command.
// [RQ11] Clock frequency changes only while in power-down or self-refresh.
// [RQ12] Auto-precharge write delay is recovery plus precharge, each rounded up.
// [RQ13] The clock runs with at least two pulses during self-refresh exit wait.
// [RQ14] The clock runs with at least one pulse during power-down exit wait.
// [RQ15] Refreshes are postponed by at most eight intervals.
// [RQ16] Nanosecond minimums become rounded-up cycle counts in per-bank, bank-to-bank and command-gap down-counters.
`timescale 1ns/1ps
module lpc_host
	import lpc_pkg::*;
(
	input  wire logic                i_clk_sys,
	input  wire logic                i_sys_rst,
	input  wire logic                i_cmd_valid,
	input  wire logic [3:0]          i_cmd,
	input  wire logic [1:0]          i_bank,
	input  wire logic [ADDR_W-1:0]   i_addr,
	input  wire logic [WDATA_W-1:0]  i_wr_data,
	output logic                     o_cmd_ack,
	output logic                     o_cmd_err,
	output logic                     o_rd_valid,
	output logic [DQ_W-1:0]          o_rd_data,
	output logic                     o_freq_change_ok,
	output logic                     o_mem_cke,
	output logic                     o_mem_cs_n,
	output logic                     o_mem_ras_n,
	output logic                     o_mem_cas_n,
	output logic                     o_mem_we_n,
	output logic [1:0]               o_mem_ba,
	output logic [ADDR_W-1:0]        o_mem_addr,
	input  wire logic [DQ_W-1:0]     i_mem_dq,
	output logic [DQ_W-1:0]          o_mem_dq,
	output logic                     o_mem_dq_oe,
	output logic                     o_mem_dqs,
	output logic                     o_mem_dqs_oe
);

	localparam logic [CNT_W-1:0] LD_XSR  = CNT_W'(XSR_CYC - 1);
	localparam logic [CNT_W-1:0] LD_XP   = CNT_W'(T_XP_CK - 1);
	localparam logic [CNT_W-1:0] LD_SRC  = CNT_W'(T_SRC_CK - 1);
	localparam logic [CNT_W-1:0] LD_MRD  = CNT_W'(T_MRD_CK - 1);
	localparam logic [CNT_W-1:0] LD_RFC  = CNT_W'(RFC_CYC - 1);
	localparam logic [CNT_W-1:0] LD_CKE  = CNT_W'(T_CKE_CK - 1);
	localparam logic [CNT_W-1:0] LD_WTR  = CNT_W'(BURST_LEN + T_WTR_CK - 1);
	localparam logic [CNT_W-1:0] LD_BUSW = CNT_W'(BURST_LEN - 1);
	localparam logic [CNT_W-1:0] LD_BUSR = CNT_W'(READ_LATENCY_CYCLES + BURST_LEN - 1);
	localparam logic [2:0]       WPH_PRE = 3'(BURST_LEN + 1);
	localparam int               RD_TAP  = READ_LATENCY_CYCLES + 2;
	localparam logic [2:0]       RBEATS  = 3'(BURST_LEN - 1);

	lpc_ctl_if ctl ();

	lpc_bank_timer u_bank_timer (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.ctl       (ctl.banks)
	);

	lpc_refresh_sched u_refresh_sched (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.ctl       (ctl.sched)
	);

	// ==========================================================
	// State.
	lpc_state_t          state_r, state_nxt;
	logic [CNT_W-1:0]    gap_r, gap_nxt;
	logic [CNT_W-1:0]    bus_r, bus_nxt;
	logic [CNT_W-1:0]    wtr_r, wtr_nxt;
	logic [CNT_W-1:0]    ckeh_r, ckeh_nxt;
	logic [BANKS-1:0]    open_r, open_nxt;
	logic                ack_r, ack_nxt;
	logic                err_r, err_nxt;
	logic                cke_r, cke_nxt;
	logic [2:0]          pin_r, pin_nxt;
	logic [1:0]          ba_r, ba_nxt;
	logic [ADDR_W-1:0]   addr_r, addr_nxt;
	logic                fok_r, fok_nxt;
	logic [2:0]          wph_r, wph_nxt;
	logic [WDATA_W-1:0]  wdat_r, wdat_nxt;
	logic [DQ_W-1:0]     dq_r, dq_nxt;
	logic                dqoe_r, dqoe_nxt;
	logic                dqs_r, dqs_nxt;
	logic                dqsoe_r, dqsoe_nxt;
	logic [RD_TAP:0]     rpipe_r, rpipe_nxt;
	logic [2:0]          rbeat_r, rbeat_nxt;
	logic [DQ_W-1:0]     dq_s1_r, dq_s2_r;
	logic [DQ_W-1:0]     rdat_r, rdat_nxt;
	logic                rval_r, rval_nxt;

	logic                take, legal, idle_banks, auto_ref;
	logic [1:0]          beat_idx;

	// ==========================================================
	// Command decision and timing counters.
	always_comb begin
		state_nxt = state_r;
		gap_nxt   = (gap_r != '0) ? gap_r - 1'b1 : gap_r;
		bus_nxt   = (bus_r != '0) ? bus_r - 1'b1 : bus_r;
		wtr_nxt   = (wtr_r != '0) ? wtr_r - 1'b1 : wtr_r;
		ckeh_nxt  = (ckeh_r != '0) ? ckeh_r - 1'b1 : ckeh_r;
		open_nxt  = open_r;
		cke_nxt   = cke_r;
		pin_nxt   = PIN_NOP;
		ba_nxt    = ba_r;
		addr_nxt  = addr_r;
		ack_nxt   = 1'b0;
		err_nxt   = 1'b0;
		ctl.act   = 1'b0;
		ctl.rd    = 1'b0;
		ctl.wr    = 1'b0;
		ctl.wra   = 1'b0;
		ctl.pre   = 1'b0;
		ctl.refr  = 1'b0;
		ctl.bank  = i_bank;
		idle_banks = (open_r == '0) && (&ctl.act_ok) && (bus_r == '0);
		take      = i_cmd_valid && !ack_r && (gap_r == '0);
		legal     = 1'b1;
		auto_ref  = 1'b0;
		if (state_r == ST_RUN) begin
			case (lpc_cmd_t'(i_cmd))
				CMD_ACT: begin
					legal = !open_r[i_bank];
					take  = take && ctl.act_ok[i_bank] && !ctl.ref_urgent; // [RQ1] [RQ3] [RQ15]
				end
				CMD_RD, CMD_SRR: begin
					legal = open_r[i_bank];
					take  = take && ctl.rw_ok[i_bank] && (bus_r == '0) && (wtr_r == '0); // [RQ2] [RQ4]
				end
				CMD_WR, CMD_WRA: begin
					legal = open_r[i_bank];
					take  = take && ctl.rw_ok[i_bank] && (bus_r == '0); // [RQ2]
				end
				CMD_PRE: begin
					legal = open_r[i_bank];
					take  = take && ctl.pre_ok[i_bank];
				end
				CMD_REF, CMD_MRS, CMD_SRE: begin
					take  = take && idle_banks && (ckeh_r == '0);
				end
				CMD_PDE: begin
					take  = take && (bus_r == '0) && (wtr_r == '0) && (ckeh_r == '0); // [RQ7]
				end
				default: begin
					legal = 1'b0;
				end
			endcase
			auto_ref = ctl.ref_due && idle_banks && (gap_r == '0) && !ack_r && (ckeh_r == '0)
			           && (!i_cmd_valid || ctl.ref_urgent || (lpc_cmd_t'(i_cmd) == CMD_PDE));
		end else begin
			legal = ((state_r == ST_PD) && (lpc_cmd_t'(i_cmd) == CMD_PDX)) ||
			        ((state_r == ST_SR) && (lpc_cmd_t'(i_cmd) == CMD_SRX));
			take  = take && (ckeh_r == '0); // [RQ7]
		end
		if (i_cmd_valid && !ack_r && !legal) begin
			ack_nxt = 1'b1;
			err_nxt = 1'b1;
		end else if (auto_ref) begin
			// Owed refresh goes first while the banks are closed, unless a request is refused or a non-urgent request other than power-down entry waits.
			pin_nxt  = PIN_REF;
			gap_nxt  = LD_RFC;
			ctl.refr = 1'b1; // [RQ15]
		end else if (take) begin
			ack_nxt  = 1'b1;
			ba_nxt   = i_bank;
			addr_nxt = i_addr;
			case (lpc_cmd_t'(i_cmd))
				CMD_ACT: begin
					pin_nxt = PIN_ACT;
					ctl.act = 1'b1;
					open_nxt[i_bank] = 1'b1;
				end
				CMD_RD, CMD_SRR: begin
					pin_nxt  = PIN_RD;
					addr_nxt[AP_BIT] = 1'b0;
					ctl.rd   = 1'b1;
					bus_nxt  = LD_BUSR;
					if (lpc_cmd_t'(i_cmd) == CMD_SRR) begin
						gap_nxt = LD_SRC; // [RQ8]
					end
				end
				CMD_WR, CMD_WRA: begin
					pin_nxt  = PIN_WR;
					addr_nxt[AP_BIT] = (lpc_cmd_t'(i_cmd) == CMD_WRA);
					ctl.wr   = (lpc_cmd_t'(i_cmd) == CMD_WR);
					ctl.wra  = (lpc_cmd_t'(i_cmd) == CMD_WRA);
					bus_nxt  = LD_BUSW;
					wtr_nxt  = LD_WTR; // [RQ4]
					if (lpc_cmd_t'(i_cmd) == CMD_WRA) begin
						open_nxt[i_bank] = 1'b0;
					end
				end
				CMD_PRE: begin
					pin_nxt = PIN_PRE;
					addr_nxt[AP_BIT] = 1'b0;
					ctl.pre = 1'b1;
					open_nxt[i_bank] = 1'b0;
				end
				CMD_REF: begin
					pin_nxt  = PIN_REF;
					gap_nxt  = LD_RFC;
					ctl.refr = 1'b1;
				end
				CMD_MRS: begin
					pin_nxt = PIN_MRS;
					gap_nxt = LD_MRD;
				end
				CMD_SRE: begin
					pin_nxt   = PIN_REF;
					cke_nxt   = 1'b0;
					ckeh_nxt  = LD_CKE; // [RQ7]
					state_nxt = ST_SR;
				end
				CMD_PDE: begin
					cke_nxt   = 1'b0;
					ckeh_nxt  = LD_CKE; // [RQ7]
					state_nxt = ST_PD;
				end
				CMD_PDX: begin
					cke_nxt   = 1'b1;
					ckeh_nxt  = LD_CKE;
					gap_nxt   = LD_XP; // [RQ6] [RQ14]
					state_nxt = ST_RUN;
				end
				default: begin
					cke_nxt   = 1'b1;
					ckeh_nxt  = LD_CKE;
					gap_nxt   = LD_XSR; // [RQ5] [RQ13]
					state_nxt = ST_RUN;
				end
			endcase
		end
		// Frequency may change only while the memory sleeps with clock enable low.
		fok_nxt = (state_nxt != ST_RUN) && (ckeh_nxt == '0); // [RQ11]
		ctl.sr_active = (state_r == ST_SR);
	end

	// ==========================================================
	// Write burst and read capture paths.
	always_comb begin
		wph_nxt  = (wph_r != '0) ? wph_r - 1'b1 : wph_r;
		wdat_nxt = wdat_r;
		if (ctl.wr || ctl.wra) begin
			wph_nxt  = WPH_PRE;
			wdat_nxt = i_wr_data;
		end
		beat_idx  = 2'(WPH_PRE - 3'h1 - wph_nxt);
		dqsoe_nxt = (wph_nxt != '0); // [RQ9]
		dqoe_nxt  = (wph_nxt != '0) && (wph_nxt != WPH_PRE);
		dqs_nxt   = dqoe_nxt && !beat_idx[0];
		dq_nxt    = dqoe_nxt ? wdat_r[beat_idx*DQ_W +: DQ_W] : '0;
		// First beat reaches the second sync stage read latency plus two after the command.
		rpipe_nxt = {rpipe_r[RD_TAP-1:0], ctl.rd}; // [RQ10]
		rbeat_nxt = (rbeat_r != '0) ? rbeat_r - 1'b1 : rbeat_r;
		rval_nxt  = 1'b0;
		rdat_nxt  = rdat_r;
		if (rpipe_r[RD_TAP] || (rbeat_r != '0)) begin
			rval_nxt = 1'b1;
			rdat_nxt = dq_s2_r;
			if (rpipe_r[RD_TAP]) begin
				rbeat_nxt = RBEATS;
			end
		end
	end

	// ==========================================================
	// Registers.
	always_ff @(posedge i_clk_sys) begin
		dq_s1_r <= i_mem_dq;
		dq_s2_r <= dq_s1_r;
		if (i_sys_rst) begin
			state_r <= ST_RUN;
			gap_r   <= '0;
			bus_r   <= '0;
			wtr_r   <= '0;
			ckeh_r  <= '0;
			open_r  <= '0;
			ack_r   <= 1'b0;
			err_r   <= 1'b0;
			cke_r   <= 1'b1;
			pin_r   <= PIN_NOP;
			ba_r    <= '0;
			addr_r  <= '0;
			fok_r   <= 1'b0;
			wph_r   <= '0;
			wdat_r  <= '0;
			dq_r    <= '0;
			dqoe_r  <= 1'b0;
			dqs_r   <= 1'b0;
			dqsoe_r <= 1'b0;
			rpipe_r <= '0;
			rbeat_r <= '0;
			rdat_r  <= '0;
			rval_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			gap_r   <= gap_nxt;
			bus_r   <= bus_nxt;
			wtr_r   <= wtr_nxt;
			ckeh_r  <= ckeh_nxt;
			open_r  <= open_nxt;
			ack_r   <= ack_nxt;
			err_r   <= err_nxt;
			cke_r   <= cke_nxt;
			pin_r   <= pin_nxt;
			ba_r    <= ba_nxt;
			addr_r  <= addr_nxt;
			fok_r   <= fok_nxt;
			wph_r   <= wph_nxt;
			wdat_r  <= wdat_nxt;
			dq_r    <= dq_nxt;
			dqoe_r  <= dqoe_nxt;
			dqs_r   <= dqs_nxt;
			dqsoe_r <= dqsoe_nxt;
			rpipe_r <= rpipe_nxt;
			rbeat_r <= rbeat_nxt;
			rdat_r  <= rdat_nxt;
			rval_r  <= rval_nxt;
		end
	end

	// Outputs come straight from flip-flops, except chip select, which is tied low.
	assign o_cmd_ack        = ack_r;
	assign o_cmd_err        = err_r;
	assign o_rd_valid       = rval_r;
	assign o_rd_data        = rdat_r;
	assign o_freq_change_ok = fok_r;
	assign o_mem_cke        = cke_r;
	assign o_mem_cs_n       = 1'b0;
	assign o_mem_ras_n      = pin_r[2];
	assign o_mem_cas_n      = pin_r[1];
	assign o_mem_we_n       = pin_r[0];
	assign o_mem_ba         = ba_r;
	assign o_mem_addr       = addr_r;
	assign o_mem_dq         = dq_r;
	assign o_mem_dq_oe      = dqoe_r;
	assign o_mem_dqs        = dqs_r;
	assign o_mem_dqs_oe     = dqsoe_r;

endmodule

// ### lpc_pkg.sv
// Package with commands, states, pin encodings and timing counts of the mobile DDR memory host.
package lpc_pkg;

	// ==========================================================
	// Clock and widths.
	localparam real CK_PERIOD_NS = 25.0;
	localparam int  BANKS        = 4;
	localparam int  DQ_W         = 16;
	localparam int  ADDR_W       = 13;
	localparam int  BURST_LEN    = 4;
	localparam int  WDATA_W      = DQ_W * BURST_LEN;
	localparam int  CNT_W        = 8;

	// Least time to whole cycles, rounded up, never below one cycle.
	function automatic int ns_to_min_cyc(input real t_ns);
		int c;
		c = int'($ceil(t_ns / CK_PERIOD_NS));
		return (c < 1) ? 1 : c;
	endfunction

	// ==========================================================
	// Timing figures as printed, slowest grade taken for each least time.
	localparam real T_RCD_NS   = 22.5;
	localparam real T_RRD_NS   = 15.0;
	localparam real T_RAS_NS   = 45.0;
	localparam real T_WR_NS    = 15.0;
	localparam real T_XSR_NS   = 120.0;
	localparam real T_RFC_NS   = 72.0;
	localparam real T_REFI_US  = 15.6;
	localparam int  T_RP_CK    = 3;
	localparam int  T_WTR_CK   = 2;
	localparam int  T_XP_CK    = 2;
	localparam int  T_CKE_CK   = 1;
	localparam int  T_MRD_CK   = 2;
	localparam int  READ_LATENCY_CYCLES = 3;
	localparam int  T_SRC_CK   = READ_LATENCY_CYCLES + 1;
	localparam int  REF_POSTPONE_MAX = 8;

	// ==========================================================
	// Derived cycle counts.
	localparam int RCD_CYC  = ns_to_min_cyc(T_RCD_NS);
	localparam int RRD_CYC  = ns_to_min_cyc(T_RRD_NS);
	localparam int RAS_CYC  = ns_to_min_cyc(T_RAS_NS);
	localparam int RC_CYC   = RAS_CYC + T_RP_CK;
	localparam int WR_CYC   = ns_to_min_cyc(T_WR_NS);
	localparam int DAL_CYC  = WR_CYC + T_RP_CK;
	localparam int XSR_CYC  = (ns_to_min_cyc(T_XSR_NS) < 2) ? 2 : ns_to_min_cyc(T_XSR_NS);
	localparam int RFC_CYC  = ns_to_min_cyc(T_RFC_NS);
	localparam int REFI_CYC = int'($floor(T_REFI_US * 1000.0 / CK_PERIOD_NS));
	localparam int REFI_W   = 12;

	// ==========================================================
	// Commands taken on the user port.
	typedef enum logic [3:0] {
		CMD_ACT = 4'h0,
		CMD_RD  = 4'h1,
		CMD_WR  = 4'h2,
		CMD_WRA = 4'h3,
		CMD_PRE = 4'h4,
		CMD_REF = 4'h5,
		CMD_MRS = 4'h6,
		CMD_SRR = 4'h7,
		CMD_SRE = 4'h8,
		CMD_SRX = 4'h9,
		CMD_PDE = 4'ha,
		CMD_PDX = 4'hb
	} lpc_cmd_t;

	// Power states of the memory as the host tracks them.
	typedef enum logic [2:0] {
		ST_RUN = 3'h1,
		ST_PD  = 3'h2,
		ST_SR  = 3'h4
	} lpc_state_t;

	// Row, column and write enable pin codes, active low.
	localparam logic [2:0] PIN_NOP = 3'h7;
	localparam logic [2:0] PIN_ACT = 3'h3;
	localparam logic [2:0] PIN_RD  = 3'h5;
	localparam logic [2:0] PIN_WR  = 3'h4;
	localparam logic [2:0] PIN_PRE = 3'h2;
	localparam logic [2:0] PIN_REF = 3'h1;
	localparam logic [2:0] PIN_MRS = 3'h0;
	localparam int         AP_BIT  = 10;

endpackage

// ### lpc_ctl_if.sv
// Interface between the command sequencer and its bank timer and refresh scheduler.
`timescale 1ns/1ps
interface lpc_ctl_if;
	logic       act;
	logic       rd;
	logic       wr;
	logic       wra;
	logic       pre;
	logic       refr;
	logic       sr_active;
	logic [1:0] bank;
	logic [3:0] act_ok;
	logic [3:0] rw_ok;
	logic [3:0] pre_ok;
	logic       ref_due;
	logic       ref_urgent;

	modport seq   (output act, rd, wr, wra, pre, refr, sr_active, bank,
	               input act_ok, rw_ok, pre_ok, ref_due, ref_urgent);
	modport banks (input act, rd, wr, wra, pre, bank, output act_ok, rw_ok, pre_ok);
	modport sched (input refr, sr_active, output ref_due, ref_urgent);
endinterface

// ### lpc_bank_timer.sv
// Per-bank down-counters that space activate, read, write and precharge commands.
`timescale 1ns/1ps
module lpc_bank_timer
	import lpc_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_sys_rst,
	lpc_ctl_if.banks  ctl
);

	localparam logic [CNT_W-1:0] LD_RC   = CNT_W'(RC_CYC - 1);
	localparam logic [CNT_W-1:0] LD_RP   = CNT_W'(T_RP_CK - 1);
	localparam logic [CNT_W-1:0] LD_DAL  = CNT_W'(BURST_LEN + DAL_CYC - 1);
	localparam logic [CNT_W-1:0] LD_RCD  = CNT_W'(RCD_CYC - 1);
	localparam logic [CNT_W-1:0] LD_RAS  = CNT_W'(RAS_CYC - 1);
	localparam logic [CNT_W-1:0] LD_WREC = CNT_W'(BURST_LEN + WR_CYC - 1);
	localparam logic [CNT_W-1:0] LD_RRD  = CNT_W'(RRD_CYC - 1);

	logic [CNT_W-1:0] rrd_r;
	logic [CNT_W-1:0] rrd_nxt;

	// ==========================================================
	// Activate to activate spacing across banks.
	always_comb begin
		rrd_nxt = (rrd_r != '0) ? rrd_r - 1'b1 : rrd_r;
		if (ctl.act) begin
			rrd_nxt = LD_RRD; // [RQ3]
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			rrd_r <= '0;
		end else begin
			rrd_r <= rrd_nxt;
		end
	end

	// ==========================================================
	// One set of counters per bank.
	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		logic [CNT_W-1:0] act_r, act_nxt;
		logic [CNT_W-1:0] rcd_r, rcd_nxt;
		logic [CNT_W-1:0] ras_r, ras_nxt;
		logic             hit;

		// Each counter holds off the dependent command until it reaches zero.
		always_comb begin
			hit     = (ctl.bank == 2'(b));
			act_nxt = (act_r != '0) ? act_r - 1'b1 : act_r;
			rcd_nxt = (rcd_r != '0) ? rcd_r - 1'b1 : rcd_r;
			ras_nxt = (ras_r != '0) ? ras_r - 1'b1 : ras_r;
			if (hit && ctl.act) begin
				act_nxt = LD_RC;   // [RQ1] [RQ16]
				rcd_nxt = LD_RCD;  // [RQ2] [RQ16]
				ras_nxt = LD_RAS;
			end else if (hit && ctl.pre) begin
				act_nxt = (act_nxt > LD_RP) ? act_nxt : LD_RP; // [RQ1]
			end else if (hit && ctl.wra) begin
				act_nxt = (act_nxt > LD_DAL) ? act_nxt : LD_DAL; // [RQ12]
			end else if (hit && ctl.wr) begin
				ras_nxt = (ras_nxt > LD_WREC) ? ras_nxt : LD_WREC;
			end
		end

		always_ff @(posedge i_clk_sys) begin
			if (i_sys_rst) begin
				act_r <= '0;
				rcd_r <= '0;
				ras_r <= '0;
			end else begin
				act_r <= act_nxt;
				rcd_r <= rcd_nxt;
				ras_r <= ras_nxt;
			end
		end

		assign ctl.act_ok[b] = (act_r == '0) && (rrd_r == '0);
		assign ctl.rw_ok[b]  = (rcd_r == '0);
		assign ctl.pre_ok[b] = (ras_r == '0);
	end

endmodule

// ### lpc_refresh_sched.sv
// Refresh interval timer that counts owed refresh commands up to the postpone limit.
`timescale 1ns/1ps
module lpc_refresh_sched
	import lpc_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_sys_rst,
	lpc_ctl_if.sched  ctl
);

	localparam logic [REFI_W-1:0] LD_REFI = REFI_W'(REFI_CYC - 1);
	localparam logic [3:0]        OWE_MAX = 4'(REF_POSTPONE_MAX);

	logic [REFI_W-1:0] tick_r;
	logic [REFI_W-1:0] tick_nxt;
	logic [3:0]        owed_r;
	logic [3:0]        owed_nxt;

	// ==========================================================
	// Interval timer; self-refresh makes owed refreshes void.
	always_comb begin
		tick_nxt = (tick_r != '0) ? tick_r - 1'b1 : LD_REFI;
		owed_nxt = owed_r;
		if (ctl.sr_active) begin
			tick_nxt = LD_REFI;
			owed_nxt = '0;
		end else begin
			if ((tick_r == '0) && (owed_nxt != OWE_MAX)) begin
				owed_nxt = owed_nxt + 1'b1;
			end
			if (ctl.refr && (owed_nxt != '0)) begin
				owed_nxt = owed_nxt - 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			tick_r <= LD_REFI;
			owed_r <= '0;
		end else begin
			tick_r <= tick_nxt;
			owed_r <= owed_nxt;
		end
	end

	assign ctl.ref_due    = (owed_r != '0);
	assign ctl.ref_urgent = (owed_r == OWE_MAX); // [RQ15]

endmodule

// ### lpc_host_properties.sv
// Concurrent checks on the memory pins of the mobile DDR host.
`timescale 1ns/1ps
module lpc_host_properties
	import lpc_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic              i_sys_rst,
	input  wire logic              o_rd_valid,
	input  wire logic              o_freq_change_ok,
	input  wire logic              o_mem_cke,
	input  wire logic              o_mem_ras_n,
	input  wire logic              o_mem_cas_n,
	input  wire logic              o_mem_we_n,
	input  wire logic [1:0]        o_mem_ba,
	input  wire logic [ADDR_W-1:0] o_mem_addr,
	input  wire logic              o_mem_dq_oe,
	input  wire logic              o_mem_dqs,
	input  wire logic              o_mem_dqs_oe
);
	// ==========================================================
	// Pin command decode.
	wire        is_act = !o_mem_ras_n && o_mem_cas_n && o_mem_we_n;
	wire        is_rd  = o_mem_ras_n && !o_mem_cas_n && o_mem_we_n;
	wire        is_wr  = o_mem_ras_n && !o_mem_cas_n && !o_mem_we_n;
	wire        is_ref = !o_mem_ras_n && !o_mem_cas_n && o_mem_we_n;
	wire        is_nop = o_mem_ras_n && o_mem_cas_n && o_mem_we_n;
	logic [1:0] act_ba_r, act_ba_nxt;
	logic [7:0] act_gap_r, act_gap_nxt;
	logic       sr_r, sr_nxt;

	// The age saturates, so a long idle spell never wraps.
	always_comb begin
		act_ba_nxt  = is_act ? o_mem_ba : act_ba_r;
		act_gap_nxt = is_act ? 8'h01 : ((act_gap_r == 8'hff) ? act_gap_r : act_gap_r + 8'h01);
		sr_nxt      = (is_ref && !o_mem_cke) ? 1'b1 : (o_mem_cke ? 1'b0 : sr_r);
	end

	// Last activate and self-refresh state.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			act_ba_r  <= 2'h0;
			act_gap_r <= 8'hff;
			sr_r      <= 1'b0;
		end else begin
			act_ba_r  <= act_ba_nxt;
			act_gap_r <= act_gap_nxt;
			sr_r      <= sr_nxt;
		end
	end

	// ==========================================================
	// Assertions.
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	same_bank_act_a: assert property (is_act && o_mem_ba == act_ba_r |-> act_gap_r >= 8'h05)
		else $error("Same-bank activate early.");
	act_act_gap_a: assert property (is_act |=> !is_act)
		else $error("Back-to-back activates.");
	write_read_gap_a: assert property (is_wr |=> !is_rd [*5])
		else $error("Read early after write.");
	sr_exit_wait_a: assert property ($rose(o_mem_cke) && sr_r |=> is_nop [*4])
		else $error("Self-refresh exit too short.");
	pd_exit_wait_a: assert property ($rose(o_mem_cke) |=> is_nop)
		else $error("Power-down exit too short.");
	cke_hold_a: assert property ($changed(o_mem_cke) |=> $stable(o_mem_cke))
		else $error("Clock enable pulse short.");
	read_gap_a: assert property (is_rd |=> !(is_rd || is_wr) [*5])
		else $error("Access early after read.");
	wr_preamble_a: assert property (is_wr |-> o_mem_dqs_oe && !o_mem_dqs ##1 o_mem_dq_oe && o_mem_dqs
		##1 o_mem_dq_oe && !o_mem_dqs)
		else $error("Write preamble missing.");
	freq_ok_a: assert property (o_freq_change_ok |-> !o_mem_cke)
		else $error("Frequency change with enable high.");
	wra_act_gap_a: assert property (is_wr && o_mem_addr[AP_BIT] |=> !is_act [*7])
		else $error("Activate early after write.");
	read_return_a: assert property (is_rd |-> ##6 o_rd_valid [*4] ##1 !o_rd_valid)
		else $error("Read beats late.");
endmodule

bind lpc_host lpc_host_properties u_props (.i_clk_sys, .i_sys_rst, .o_rd_valid, .o_freq_change_ok, .o_mem_cke,
	.o_mem_ras_n, .o_mem_cas_n, .o_mem_we_n, .o_mem_ba, .o_mem_addr, .o_mem_dq_oe, .o_mem_dqs, .o_mem_dqs_oe);

// ### lpc_mem_model.sv
// Behavioural mobile DDR memory that answers reads.
`timescale 1ns/1ps
module lpc_mem_model
	import lpc_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_cke,
	input  wire logic              i_ras_n,
	input  wire logic              i_cas_n,
	input  wire logic              i_we_n,
	input  wire logic [1:0]        i_ba,
	input  wire logic [ADDR_W-1:0] i_addr,
	output logic      [DQ_W-1:0]   o_dq
);
	int         phase = 0;
	logic [1:0] ba_r  = 2'h0;
	logic [5:0] col_r = 6'h00;

	// Pins are sampled at the edge; outside a burst the bus toggles.
	always @(posedge i_clk) begin
		if (i_cke && i_ras_n && !i_cas_n && i_we_n) begin
			phase = 1;
			ba_r  = i_ba;
			col_r = i_addr[5:0];
		end else if (phase != 0) begin
			phase = (phase == 6) ? 0 : phase + 1;
		end
		#1;
		if (phase >= READ_LATENCY_CYCLES && phase < READ_LATENCY_CYCLES + 4)
			o_dq = {4'ha, 2'h0, ba_r, col_r, 2'(phase - READ_LATENCY_CYCLES)};
		else
			o_dq = (o_dq === 16'hxxxx) ? 16'h5a5a : ~o_dq;
	end
endmodule

// ### tb_lpc_host.sv
// Self-checking testbench of the mobile DDR host.
`timescale 1ns/1ps
module tb_lpc_host;
	import lpc_pkg::*;
	logic                i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_cmd_valid = 1'b0;
	logic [3:0]          i_cmd     = 4'h0;
	logic [1:0]          i_bank    = 2'h0, o_mem_ba;
	logic [ADDR_W-1:0]   i_addr    = 13'h0000, o_mem_addr;
	logic [WDATA_W-1:0]  i_wr_data = 64'h0;
	logic [DQ_W-1:0]     i_mem_dq, o_mem_dq, o_rd_data, mem_dq;
	logic                o_cmd_ack, o_cmd_err, o_rd_valid, o_freq_change_ok, o_mem_cke, o_mem_cs_n;
	logic                o_mem_ras_n, o_mem_cas_n, o_mem_we_n, o_mem_dq_oe, o_mem_dqs, o_mem_dqs_oe;
	int                  bad_count = 0, n_checks = 0, cyc = 0, t_ack = 0, ref_seen = 0;
	logic [DQ_W-1:0]     rq[$];

	// Data wire: whichever side drives it.
	assign i_mem_dq = o_mem_dq_oe ? o_mem_dq : mem_dq;

	lpc_host DUT (.i_clk_sys, .i_sys_rst, .i_cmd_valid, .i_cmd, .i_bank, .i_addr, .i_wr_data, .o_cmd_ack,
		.o_cmd_err, .o_rd_valid, .o_rd_data, .o_freq_change_ok, .o_mem_cke, .o_mem_cs_n, .o_mem_ras_n,
		.o_mem_cas_n, .o_mem_we_n, .o_mem_ba, .o_mem_addr, .i_mem_dq, .o_mem_dq, .o_mem_dq_oe, .o_mem_dqs,
		.o_mem_dqs_oe);
	lpc_mem_model MEM (.i_clk(i_clk_sys), .i_cke(o_mem_cke), .i_ras_n(o_mem_ras_n), .i_cas_n(o_mem_cas_n),
		.i_we_n(o_mem_we_n), .i_ba(o_mem_ba), .i_addr(o_mem_addr), .o_dq(mem_dq));

	// Clock of 25 ns.
	initial begin
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	// Cycle count, read beats and refreshes seen on the pins.
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (o_rd_valid === 1'b1) rq.push_back(o_rd_data);
		if (o_mem_cke && !o_mem_ras_n && !o_mem_cas_n && o_mem_we_n) ref_seen <= ref_seen + 1;
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	// One request, held until acknowledged; checks ack and refusal flag.
	task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a = 13'h0, input logic e = 1'b0);
		int n = 0;
		idle(1);
		i_cmd = c;
		i_bank = b;
		i_addr = a;
		i_cmd_valid = 1'b1;
		do begin
			idle(1);
			n++;
		end while (o_cmd_ack !== 1'b1 && n < 3000);
		i_cmd_valid = 1'b0;
		t_ack = cyc;
		check(64'({o_cmd_ack, o_cmd_err}), 64'({1'b1, e}));
	endtask

	task automatic t_rw();
		int i, tw;
		check(64'({o_mem_cke, o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n, o_freq_change_ok, o_mem_dq_oe}), 64'h5c);
		i_wr_data = 64'h4444_3333_2222_1111;
		issue(4'h0, 2'h3, 13'h0123);
		issue(4'h2, 2'h3, 13'h0015);
		tw = t_ack;
		for (i = 0; i < 4; i++) begin
			idle(1);
			check(64'({o_mem_dq_oe, o_mem_dq}), 64'({1'b1, i_wr_data[16*i +: 16]}));
		end
		rq.delete();
		issue(4'h1, 2'h3, 13'h0015);
		check(64'(t_ack - tw >= 6), 64'h1);
		idle(12);
		check(64'(rq.size()), 64'h4);
		for (i = 0; i < 4; i++) check(64'(rq[i]), 64'({4'ha, 2'h0, 2'h3, 6'h15, 2'(i)}));
		issue(4'h4, 2'h3);
		$display("test read write done");
	endtask

	task automatic t_act();
		int ta;
		issue(4'h0, 2'h2, 13'h0001);
		issue(4'h0, 2'h1, 13'h0002);
		ta = t_ack;
		issue(4'h0, 2'h1, 13'h0002, 1'b1);
		issue(4'h4, 2'h1);
		issue(4'h0, 2'h1, 13'h0003);
		check(64'(t_ack - ta >= 5), 64'h1);
		issue(4'h4, 2'h1);
		issue(4'h4, 2'h2);
		issue(4'h0, 2'h0, 13'h0004);
		issue(4'h3, 2'h0, 13'h0008);
		ta = t_ack;
		issue(4'h0, 2'h0, 13'h0005);
		check(64'(t_ack - ta >= 8), 64'h1);
		issue(4'h4, 2'h0);
		$display("test activate spacing done");
	endtask

	task automatic t_status();
		int ta;
		issue(4'h6, 2'h0);
		issue(4'h0, 2'h0, 13'h0006);
		issue(4'h7, 2'h0);
		ta = t_ack;
		issue(4'h0, 2'h1, 13'h0006);
		check(64'(t_ack - ta >= 4), 64'h1);
		issue(4'h4, 2'h0);
		issue(4'h4, 2'h1);
		issue(4'hf, 2'h0, 13'h0000, 1'b1);
		issue(4'h1, 2'h2, 13'h0000, 1'b1);
		$display("test status read done");
	endtask

	// Self-refresh, then power-down: entry and exit.
	task automatic t_low_power();
		int ta, k;
		for (k = 0; k < 2; k++) begin
			issue(k ? 4'ha : 4'h8, 2'h0);
			idle(3);
			check(64'({o_mem_cke, o_freq_change_ok}), 64'h1);
			issue(4'h0, 2'h0, 13'h0000, 1'b1);
			issue(k ? 4'hb : 4'h9, 2'h0);
			ta = t_ack;
			check(64'(o_mem_cke), 64'h1);
			issue(4'h0, 2'h0, 13'h0007);
			check(64'(t_ack - ta >= (k ? 2 : 5)), 64'h1);
			issue(4'h4, 2'h0);
		end
		$display("test low power done");
	endtask

	task automatic t_refresh();
		int r0;
		r0 = ref_seen;
		idle(1300);
		check(64'(ref_seen - r0 >= 2), 64'h1);
		$display("test refresh done");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence after a 16-cycle reset.
	initial begin
		repeat (16) @(posedge i_clk_sys);
		#1;
		i_sys_rst = 1'b0;
		t_rw();
		t_act();
		t_status();
		t_low_power();
		t_refresh();
		final_report();
	end

	// Watchdog far past the expected run.
	initial begin
		#500000;
		bad_count++;
		final_report();
	end
endmodule
